/* File: irqagg_mcu_model.sv */
module irqagg_mcu_model
    import irqagg_pkg::*;
(
    // Answer from the block
    input  wire logic       mclk,
    input  wire logic       d2d_ack,
    input  wire logic [7:0] d2d_rdata,
    // Request toward the block
    output irqagg_req_s     d2d_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial d2d_req = '0;
    // One-cycle strobe, stale bus inverted, bounded wait for ack
    task automatic access(input logic wr, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        d2d_req <= '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge mclk);
        d2d_req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (d2d_ack !== 1'b1 && n < 3);
        q = d2d_rdata;
        ok = d2d_ack;
    endtask
endmodule

/* File: irqagg_pkg.sv */
package irqagg_pkg;

    // Die-to-die window bases and register offsets
    localparam logic [15:0] BASE_BLOCKING    = 16'h0E00;
    localparam logic [15:0] BASE_NONBLOCKING = 16'h0F00;
    localparam logic [7:0]  OFS_SRC_HIGH     = 8'h08;
    localparam logic [7:0]  OFS_SRC_LOW      = 8'h09;
    localparam logic [7:0]  OFS_VECTOR       = 8'h0A;
    localparam logic [7:0]  OFS_RESERVED     = 8'h0B;
    localparam logic [7:0]  OFS_DISABLE_HIGH = 8'h0C;
    localparam logic [7:0]  OFS_DISABLE_LOW  = 8'h0D;

    // Source count and reset values
    localparam int          NUM_SOURCES      = 14;
    localparam logic [7:0]  DISABLE_RESET    = 8'h00;
    localparam logic [7:0]  LOW_USED_MASK    = 8'h3F;
    localparam logic [4:0]  VECTOR_NONE      = 5'h00;

    // Pending sources in priority order, bit 0 highest (code 1)
    typedef struct packed {
        logic calibration_request_pending;
        logic lifetime_counter_pending;
        logic measurement_done_pending;
        logic serial_receive_pending;
        logic serial_transmit_pending;
        logic serial_error_pending;
        logic timer_overflow_pending;
        logic timer_chan3_pending;
        logic timer_chan2_pending;
        logic timer_chan1_pending;
        logic timer_chan0_pending;
        logic lin_fault_pending;
        logic high_temp_pending;
        logic undervoltage_pending;
    } irqagg_sources_s;

    // Register access request from the die-to-die window
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } irqagg_req_s;

endpackage

/* File: irqagg_prio.sv */
module irqagg_prio
    import irqagg_pkg::*;
(
    // Enabled request vector, priority order
    input  wire logic [NUM_SOURCES-1:0] req,
    // Code of the highest priority request
    output logic      [4:0]             code
);

    // Lowest index wins; code is index plus one
    always_comb begin
        code = VECTOR_NONE;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (req[i]) begin
                code = 5'(i + 1); // [RL7]
            end
        end
    end

endmodule

/* File: irqagg_sva.sv */
module irqagg_sva
    import irqagg_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Source unit request levels
    input wire logic        timer_overflow_pending,
    input wire logic        timer_chan3_pending,
    input wire logic        timer_chan2_pending,
    input wire logic        timer_chan1_pending,
    input wire logic        timer_chan0_pending,
    input wire logic        lin_overtemp_req,
    input wire logic        lin_dominant_timeout_req,
    input wire logic        high_temp_pending,
    input wire logic        undervoltage_req,
    input wire logic        cranking_wakeup_req,
    input wire logic        calibration_request_pending,
    input wire logic        lifetime_counter_pending,
    input wire logic        measurement_done_pending,
    input wire logic        serial_receive_pending,
    input wire logic        serial_transmit_pending,
    input wire logic        serial_error_pending,
    // Die-to-die register window
    input wire irqagg_req_s d2d_req,
    input wire logic        d2d_ack,
    input wire logic [7:0]  d2d_rdata,
    // Interrupt toward the microcontroller
    input wire logic        die_link_interrupt_out
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    logic [13:0] src, dis, en;
    logic [7:0]  o;
    logic [4:0]  vec;
    logic        rq, rd;
    // Live sources, window decode, expected code
    assign src = {calibration_request_pending, lifetime_counter_pending,
        measurement_done_pending, serial_receive_pending,
        serial_transmit_pending, serial_error_pending, timer_overflow_pending,
        timer_chan3_pending, timer_chan2_pending, timer_chan1_pending,
        timer_chan0_pending, lin_overtemp_req | lin_dominant_timeout_req,
        high_temp_pending, undervoltage_req | cranking_wakeup_req};
    assign en = src & ~dis;
    assign o = d2d_req.addr[7:0];
    assign rq = (d2d_req.rd | d2d_req.wr) & (d2d_req.addr[15:9] == 7'h07);
    assign rd = rq & d2d_req.rd;
    always_comb begin
        vec = 5'h00;
        for (int j = 13; j >= 0; j--)
            if (en[j]) vec = 5'(j + 1);
    end
    // Shadow of the disable registers
    always_ff @(posedge mclk) begin
        if (srst)
            dis <= '0;
        else if (rq && d2d_req.wr && o == OFS_DISABLE_HIGH)
            dis[7:0] <= d2d_req.wdata;
        else if (rq && d2d_req.wr && o == OFS_DISABLE_LOW)
            dis[13:8] <= d2d_req.wdata[5:0];
    end
    property p_ack; rq |=> d2d_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_nak; !rq |=> !d2d_ack; endproperty
    a_nak: assert property (p_nak) else $error("stray ack");
    property p_shi; rd && o == OFS_SRC_HIGH |=> d2d_rdata == $past(src[7:0]);
    endproperty
    a_shi: assert property (p_shi) else $error("bad src hi");
    property p_slo; rd && o == OFS_SRC_LOW |=>
        d2d_rdata == {2'b00, $past(src[13:8])}; endproperty
    a_slo: assert property (p_slo) else $error("bad src lo");
    property p_vec; rd && o == OFS_VECTOR |=>
        d2d_rdata == {3'b000, $past(vec)}; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_dhi; rd && o == OFS_DISABLE_HIGH |=>
        d2d_rdata == $past(dis[7:0]); endproperty
    a_dhi: assert property (p_dhi) else $error("bad dis hi");
    property p_dlo; rd && o == OFS_DISABLE_LOW |=>
        d2d_rdata == {2'b00, $past(dis[13:8])}; endproperty
    a_dlo: assert property (p_dlo) else $error("bad dis lo");
    property p_irq; !srst |=> die_link_interrupt_out == $past(|en);
    endproperty
    a_irq: assert property (p_irq) else $error("bad irq");
    c_irq: cover property ($rose(die_link_interrupt_out));
    c_vec: cover property (rd && o == OFS_VECTOR && |en);
    c_dis: cover property (rq && d2d_req.wr && o == OFS_DISABLE_LOW);
endmodule

bind irqagg_top irqagg_sva u_sva (
    .mclk                        (mclk),
    .srst                        (srst),
    .timer_overflow_pending      (timer_overflow_pending),
    .timer_chan3_pending         (timer_chan3_pending),
    .timer_chan2_pending         (timer_chan2_pending),
    .timer_chan1_pending         (timer_chan1_pending),
    .timer_chan0_pending         (timer_chan0_pending),
    .lin_overtemp_req            (lin_overtemp_req),
    .lin_dominant_timeout_req    (lin_dominant_timeout_req),
    .high_temp_pending           (high_temp_pending),
    .undervoltage_req            (undervoltage_req),
    .cranking_wakeup_req         (cranking_wakeup_req),
    .calibration_request_pending (calibration_request_pending),
    .lifetime_counter_pending    (lifetime_counter_pending),
    .measurement_done_pending    (measurement_done_pending),
    .serial_receive_pending      (serial_receive_pending),
    .serial_transmit_pending     (serial_transmit_pending),
    .serial_error_pending        (serial_error_pending),
    .d2d_req                     (d2d_req),
    .d2d_ack                     (d2d_ack),
    .d2d_rdata                   (d2d_rdata),
    .die_link_interrupt_out      (die_link_interrupt_out)
);

/* File: irqagg_tb_top.sv */
module irqagg_tb_top
    import irqagg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, srst, ack, irq, ok;
    logic [15:0] s, r, b;
    logic [13:0] dis;
    logic [7:0]  rdata, q;
    irqagg_req_s req;
    int          n_fail = 0, n_compared = 0;
    irqagg_top dut (.mclk(mclk), .srst(srst), .undervoltage_req(s[0]),
        .cranking_wakeup_req(s[1]), .high_temp_pending(s[2]),
        .lin_overtemp_req(s[3]), .lin_dominant_timeout_req(s[4]),
        .timer_chan0_pending(s[5]), .timer_chan1_pending(s[6]),
        .timer_chan2_pending(s[7]), .timer_chan3_pending(s[8]),
        .timer_overflow_pending(s[9]), .serial_error_pending(s[10]),
        .serial_transmit_pending(s[11]), .serial_receive_pending(s[12]),
        .measurement_done_pending(s[13]), .lifetime_counter_pending(s[14]),
        .calibration_request_pending(s[15]), .d2d_req(req), .d2d_ack(ack),
        .d2d_rdata(rdata), .die_link_interrupt_out(irq));
    irqagg_mcu_model mcu (.mclk(mclk), .d2d_ack(ack), .d2d_rdata(rdata),
        .d2d_req(req));
    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Expected read data; FF selects the interrupt level
    function automatic logic [7:0] want(logic [7:0] o);
        logic [13:0] p, e;
        logic [7:0]  v;
        p = {s[15:5], s[4] | s[3], s[2], s[1] | s[0]};
        e = p & ~dis;
        v = 8'h00;
        for (int j = 13; j >= 0; j--)
            if (e[j]) v = 8'(j + 1);
        case (o)
            OFS_SRC_HIGH:     return p[7:0];
            OFS_SRC_LOW:      return {2'b00, p[13:8]};
            OFS_VECTOR:       return v;
            OFS_DISABLE_HIGH: return dis[7:0];
            OFS_DISABLE_LOW:  return {2'b00, dis[13:8]};
            8'hFF:            return {7'h00, |e};
            default:          return 8'h00;
        endcase
    endfunction
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Register access that must be answered
    task automatic acc(logic wr, logic [7:0] o, logic [7:0] d);
        mcu.access(wr, b | 16'(o), d, q, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            end_of_test();
        end else begin
            if (wr && o == OFS_DISABLE_HIGH) dis[7:0] = d;
            if (wr && o == OFS_DISABLE_LOW) dis[13:8] = d[5:0];
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Single sources first, then random levels and disables
    initial begin
        srst = 1'b1;
        s = '0;
        r = 16'h0024;
        dis = '0;
        b = BASE_BLOCKING;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        mcu.access(1'b0, 16'h0D0C, 8'h00, q, ok);
        chk({7'h00, ok}, 8'h00);
        // Refused write; the first disable read must still show zero
        mcu.access(1'b1, 16'h100C, 8'hFF, q, ok);
        chk({7'h00, ok}, 8'h00);
        for (int i = 0; i < 60; i++) begin
            r = lfsr(r);
            b = i[0] ? BASE_NONBLOCKING : BASE_BLOCKING;
            s <= (i < 16) ? 16'(1) << i : r;
            if (i >= 16) begin
                acc(1'b1, OFS_DISABLE_HIGH, r[7:0] & r[11:4]);
                acc(1'b1, OFS_DISABLE_LOW, r[15:8]);
                acc(1'b1, 8'(8 + i % 4), r[7:0]);
            end
            for (int o = 8; o < 15; o++) begin
                acc(1'b0, 8'(o), 8'h00);
                chk(q, want(8'(o)));
            end
            chk({7'h00, irq}, want(8'hFF));
        end
        // Reset in mid-run clears both disable bytes
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        dis = '0;
        @(posedge mclk);
        acc(1'b0, OFS_DISABLE_HIGH, 8'h00);
        chk(q, want(OFS_DISABLE_HIGH));
        acc(1'b0, OFS_DISABLE_LOW, 8'h00);
        chk(q, want(OFS_DISABLE_LOW));
        chk({7'h00, irq}, want(8'hFF));
        end_of_test();
    end
endmodule

/* File: irqagg_top.sv */
// Operation
// RL1 - Read-only 0x08: overflow, channels 3..0, LIN, temp, undervoltage.
// RL2 - Each source bit reads 1 while its request is pending, else 0.
// RL3 - Undervoltage bit also reads 1 after wake-up from cranking mode.
// RL4 - Read-only 0x09: calibration, lifetime, measurement, serial; 7:6 zero.
// RL5 - LIN fault bit: driver overtemperature or transmit dominant timeout.
// RL6 - Offsets decode relative to 0x0E00 blocking and 0x0F00 non-blocking.
// RL7 - Vector gives highest priority pending code 1..14, zero if none.
// RL8 - Global disable bits: 0 enables, 1 disables; all reset to 0.
// RL9 - Reading source or vector registers never acknowledges any request.
// RL10 - Interrupt high if any enabled source pends; status writes ignored.
module irqagg_top
    import irqagg_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // Source unit request levels
    input  wire logic        timer_overflow_pending,
    input  wire logic        timer_chan3_pending,
    input  wire logic        timer_chan2_pending,
    input  wire logic        timer_chan1_pending,
    input  wire logic        timer_chan0_pending,
    input  wire logic        lin_overtemp_req,
    input  wire logic        lin_dominant_timeout_req,
    input  wire logic        high_temp_pending,
    input  wire logic        undervoltage_req,
    input  wire logic        cranking_wakeup_req,
    input  wire logic        calibration_request_pending,
    input  wire logic        lifetime_counter_pending,
    input  wire logic        measurement_done_pending,
    input  wire logic        serial_receive_pending,
    input  wire logic        serial_transmit_pending,
    input  wire logic        serial_error_pending,
    // Die-to-die register window
    input  wire irqagg_req_s d2d_req,
    output logic             d2d_ack,
    output logic      [7:0]  d2d_rdata,
    // Interrupt toward the microcontroller
    output logic             die_link_interrupt_out
);

    irqagg_sources_s             src;
    logic [NUM_SOURCES-1:0]      src_vec;
    logic [NUM_SOURCES-1:0]      enabled_vec;
    logic [7:0]                  global_source_disable_high;
    logic [7:0]                  global_source_disable_low;
    logic [4:0]                  top_code;
    logic                        hit;
    logic [7:0]                  ofs;
    logic [7:0]                  pending_sources_high;
    logic [7:0]                  pending_sources_low;
    logic [7:0]                  next_rdata;
    logic [7:0]                  vector_byte;
    logic                        any_enabled;
    logic                        rd_hit;
    logic                        wr_hit;
    // Named disable fields, high byte
    logic                        timer_overflow_disable;
    logic                        timer_chan3_disable;
    logic                        timer_chan2_disable;
    logic                        timer_chan1_disable;
    logic                        timer_chan0_disable;
    logic                        lin_fault_disable;
    logic                        high_temp_disable;
    logic                        undervoltage_disable;
    // Named disable fields, low byte
    logic                        calibration_request_disable;
    logic                        lifetime_counter_disable;
    logic                        measurement_done_disable;
    logic                        serial_receive_disable;
    logic                        serial_transmit_disable;
    logic                        serial_error_disable;

    // Window decode against either base
    function automatic logic in_window(input logic [15:0] a);
        return (a[15:8] == BASE_BLOCKING[15:8])
            || (a[15:8] == BASE_NONBLOCKING[15:8]); // [RL6]
    endfunction

    // Source mirror, live levels, no latching
    always_comb begin
        src.undervoltage_pending        = undervoltage_req
                                        | cranking_wakeup_req; // [RL3]
        src.high_temp_pending           = high_temp_pending;
        src.lin_fault_pending           = lin_overtemp_req
                                        | lin_dominant_timeout_req; // [RL5]
        src.timer_chan0_pending         = timer_chan0_pending;
        src.timer_chan1_pending         = timer_chan1_pending;
        src.timer_chan2_pending         = timer_chan2_pending;
        src.timer_chan3_pending         = timer_chan3_pending;
        src.timer_overflow_pending      = timer_overflow_pending;
        src.serial_error_pending        = serial_error_pending;
        src.serial_transmit_pending     = serial_transmit_pending;
        src.serial_receive_pending      = serial_receive_pending;
        src.measurement_done_pending    = measurement_done_pending;
        src.lifetime_counter_pending    = lifetime_counter_pending;
        src.calibration_request_pending = calibration_request_pending;
    end

    // Flat view of the mirror, bit 0 highest priority
    assign src_vec = src; // [RL2]

    // High byte: overflow, ch3..ch0, LIN, temp, undervoltage
    assign pending_sources_high = {src_vec[7], src_vec[6], src_vec[5],
                                   src_vec[4], src_vec[3], src_vec[2],
                                   src_vec[1], src_vec[0]}; // [RL1]
    // Low byte: cal, lifetime, measurement, rx, tx, err
    assign pending_sources_low  = {2'h0, src_vec[13], src_vec[12],
                                   src_vec[11], src_vec[10], src_vec[9],
                                   src_vec[8]}; // [RL4]

    // Disable fields, high byte
    assign timer_overflow_disable      = global_source_disable_high[7];
    assign timer_chan3_disable         = global_source_disable_high[6];
    assign timer_chan2_disable         = global_source_disable_high[5];
    assign timer_chan1_disable         = global_source_disable_high[4];
    assign timer_chan0_disable         = global_source_disable_high[3];
    assign lin_fault_disable           = global_source_disable_high[2];
    assign high_temp_disable           = global_source_disable_high[1];
    assign undervoltage_disable        = global_source_disable_high[0];
    // Disable fields, low byte
    assign calibration_request_disable = global_source_disable_low[5];
    assign lifetime_counter_disable    = global_source_disable_low[4];
    assign measurement_done_disable    = global_source_disable_low[3];
    assign serial_receive_disable      = global_source_disable_low[2];
    assign serial_transmit_disable     = global_source_disable_low[1];
    assign serial_error_disable        = global_source_disable_low[0];

    // A set disable bit hides its source from vector and line
    assign enabled_vec = src_vec & ~{calibration_request_disable,
                                     lifetime_counter_disable,
                                     measurement_done_disable,
                                     serial_receive_disable,
                                     serial_transmit_disable,
                                     serial_error_disable,
                                     timer_overflow_disable,
                                     timer_chan3_disable,
                                     timer_chan2_disable,
                                     timer_chan1_disable,
                                     timer_chan0_disable,
                                     lin_fault_disable,
                                     high_temp_disable,
                                     undervoltage_disable}; // [RL8]

    // Priority encoder over enabled pending sources
    irqagg_prio u_prio (
        .req  (enabled_vec),
        .code (top_code)
    );

    assign ofs = d2d_req.addr[7:0];
    assign hit = in_window(d2d_req.addr);
    // Accepted strobes; requests outside both windows are dropped
    assign rd_hit = d2d_req.rd && hit; // [RL6]
    assign wr_hit = d2d_req.wr && hit;

    // Vector byte; upper three bits read zero
    assign vector_byte = {3'h0, top_code}; // [RL7]

    // Any enabled source pending
    assign any_enabled = |enabled_vec; // [RL10]

    // Disable high byte; status offsets accept no write
    always_ff @(posedge mclk) begin
        if (srst) begin
            global_source_disable_high <= DISABLE_RESET; // [RL8]
        end else if (wr_hit && ofs == OFS_DISABLE_HIGH) begin // [RL10]
            global_source_disable_high <= d2d_req.wdata;
        end
    end

    // Disable low byte; unused top bits stay zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            global_source_disable_low <= DISABLE_RESET; // [RL8]
        end else if (wr_hit && ofs == OFS_DISABLE_LOW) begin
            global_source_disable_low <= d2d_req.wdata & LOW_USED_MASK;
        end
    end

    // Read mux; reads have no side effects on any source
    always_comb begin
        next_rdata = 8'h00;
        if (hit) begin
            unique case (ofs)
                OFS_SRC_HIGH:     next_rdata = pending_sources_high; // [RL9]
                OFS_SRC_LOW:      next_rdata = pending_sources_low;
                OFS_VECTOR:       next_rdata = vector_byte;
                OFS_RESERVED:     next_rdata = 8'h00;
                OFS_DISABLE_HIGH: next_rdata = global_source_disable_high;
                OFS_DISABLE_LOW:  next_rdata = global_source_disable_low;
                default:          next_rdata = 8'h00;
            endcase
        end
    end

    // Acknowledge one cycle after an accepted access
    always_ff @(posedge mclk) begin
        if (srst) begin
            d2d_ack <= 1'b0;
        end else begin
            d2d_ack <= rd_hit || wr_hit; // [RL6]
        end
    end

    // Read data, held until the next accepted read
    always_ff @(posedge mclk) begin
        if (srst) begin
            d2d_rdata <= 8'h00;
        end else if (rd_hit) begin
            d2d_rdata <= next_rdata; // [RL9]
        end
    end

    // Registered interrupt line
    always_ff @(posedge mclk) begin
        if (srst) begin
            die_link_interrupt_out <= 1'b0;
        end else begin
            die_link_interrupt_out <= any_enabled; // [RL10]
        end
    end

endmodule
